/* File: design/mul_div_params.svh */
// Purpose: Constants of the nibble-wide multiply/divide unit.
// Assumes: CPU clock drives the unit; I/O bus on the same clock.
// Notes: Addresses are full 16-bit I/O memory addresses.
//
// How it works
// - Operands are unsigned; 8x8 multiply and 16/8 divide are offered.
// - Multiply: multiplier in source, multiplicand in low dest, write 0.
// - Multiply ends 10 clocks after start; product and flags load together.
// - Multiply negative flag copies bit 7 of high dest byte.
// - Multiply always clears overflow flag.
// - Multiply zero flag is set when whole 16-bit product is zero.
// - Divide: divisor in source, dividend across dest bytes, write 1.
// - Divide ends 10 clocks after start; quotient low, remainder high.
// - Divide overflow flag set when quotient needs more than 8 bits.
// - On divide overflow both dest bytes keep the dividend.
// - Divide negative flag copies bit 7 of low dest byte.
// - Divide zero flag is set when low dest byte is zero.
// - Source operand keeps its value until software writes it again.
// - Bytes are nibble pairs at ff80..ff85, low nibble at lower address.
// - Dest contents are captured at the start write and used from there.
// - Multiply ignores the high dest byte as an input.
// - Source and dest bytes have no reset value.
// - Negative flag is read-only and resets to zero.
// - Mode-start bit reads one while busy, zero when done; resets zero.
// - Overflow and zero flags are read-only and reset to zero.
`ifndef MUL_DIV_PARAMS_SVH
`define MUL_DIV_PARAMS_SVH

`define MDU_ADDR_SRC_LO 16'hff80
`define MDU_ADDR_SRC_HI 16'hff81
`define MDU_ADDR_DLO_LO 16'hff82
`define MDU_ADDR_DLO_HI 16'hff83
`define MDU_ADDR_DHI_LO 16'hff84
`define MDU_ADDR_DHI_HI 16'hff85
`define MDU_ADDR_CTRL 16'hff86

`define MDU_BIT_NEG 3
`define MDU_BIT_OVF 2
`define MDU_BIT_ZERO 1
`define MDU_BIT_MODE 0

`define MDU_MODE_MUL 1'b0
`define MDU_MODE_DIV 1'b1

`define MDU_CTRL_RESET 4'h0
`define MDU_RDATA_RESET 4'h0

`define MDU_OP_CYCLES 10
`define MDU_BUS_CYCLES 5

`endif

/* File: design/mul_div_pkg.sv */
// Purpose: Types of the multiply/divide unit.
// Assumes: Nothing beyond the constants header.
// Notes: Carries the I/O bus request and the flag group.
package mul_div_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [3:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
  } arith_flags_s;

  typedef enum {ST_IDLE, ST_RUN} op_state_e;

endpackage

/* File: design/mul_div_unit.sv */
// Purpose: Unsigned 8x8 multiply and 16/8 divide on nibble I/O registers.
// Assumes: io_req comes from the CPU core on mclk, one access a cycle.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
`include "mul_div_params.svh"

module mul_div_unit #(
  parameter int unsigned OP_CYCLES = `MDU_OP_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire mul_div_pkg::io_req_s io_req,
  output logic [3:0] io_rdata_r
);
  import mul_div_pkg::*;

  if (OP_CYCLES < 1 || OP_CYCLES > 255) begin : g_chk
    $error("OP_CYCLES must lie in 1..255");
  end

  localparam int NIBS = 6;

  logic [3:0] nib_r [0:NIBS-1];
  logic [7:0] src;
  logic [7:0] dlo;
  logic [7:0] dhi;
  logic [15:0] dest16;
  logic start;
  logic done;
  logic busy;
  op_state_e st_r;
  logic [7:0] cnt_r;
  logic mode_r;
  logic [7:0] cap_src_r;
  logic [7:0] cap_lo_r;
  logic [7:0] cap_hi_r;
  arith_flags_s flg_r;
  arith_flags_s flg_nxt;
  logic [15:0] prod;
  logic [15:0] dvd;
  logic [15:0] dvs;
  logic [7:0] quo;
  logic [7:0] rem;
  logic ovf;
  logic res_we;
  logic [15:0] res16;
  logic [7:0] nxt_lo;
  logic [3:0] rd_mux;

  // Byte views of the nibble store
  assign src = {nib_r[1], nib_r[0]};
  assign dlo = {nib_r[3], nib_r[2]};
  assign dhi = {nib_r[5], nib_r[4]};
  assign dest16 = {dhi, dlo};

  // Any write to the control nibble starts an operation
  assign start = io_req.wr && (io_req.addr == `MDU_ADDR_CTRL);
  assign busy = (st_r == ST_RUN);
  assign done = busy && (cnt_r == 8'h01);

  // Operation sequencer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (start) begin
            st_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (start) begin
            st_r <= ST_RUN;
          end else if (done) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Cycle counter to completion
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
    end else if (start) begin
      cnt_r <= 8'(OP_CYCLES);
    end else if (busy) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  // Mode latched from the start write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= `MDU_MODE_MUL;
    end else if (start) begin
      mode_r <= io_req.wdata[`MDU_BIT_MODE];
    end
  end

  // Operand capture at start
  always_ff @(posedge mclk) begin
    if (start) begin
      cap_src_r <= src;
      cap_lo_r <= dlo;
      if (io_req.wdata[`MDU_BIT_MODE] == `MDU_MODE_DIV) begin
        cap_hi_r <= dhi;
      end else begin
        cap_hi_r <= 8'h00;
      end
    end
  end

  // Arithmetic on captured operands only
  always_comb begin
    prod = {8'h00, cap_lo_r} * {8'h00, cap_src_r};
    dvd = {cap_hi_r, cap_lo_r};
    ovf = (cap_hi_r >= cap_src_r);
    dvs = {8'h00, (ovf ? 8'h01 : cap_src_r)};
    quo = 8'(dvd / dvs);
    rem = 8'(dvd % dvs);
    res_we = (mode_r == `MDU_MODE_MUL) || !ovf;
    res16 = (mode_r == `MDU_MODE_DIV) ? {rem, quo} : prod;
    nxt_lo = res_we ? res16[7:0] : dlo;
  end

  // Flag values at completion
  always_comb begin
    if (mode_r == `MDU_MODE_MUL) begin
      flg_nxt.neg = prod[15];
      flg_nxt.ovf = 1'b0;
      flg_nxt.zero = (prod == 16'h0000);
    end else begin
      flg_nxt.neg = nxt_lo[7];
      flg_nxt.ovf = ovf;
      flg_nxt.zero = (nxt_lo == 8'h00);
    end
  end

  // Flags change only at completion
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flg_r <= '0;
    end else if (done) begin
      flg_r <= flg_nxt;
    end
  end

  // Nibble store, no reset
  for (genvar i = 0; i < NIBS; i++) begin : g_nib
    localparam logic [15:0] NIB_ADDR = `MDU_ADDR_SRC_LO + 16'(i);
    logic hit;
    assign hit = io_req.wr && (io_req.addr == NIB_ADDR);
    if (i >= 2) begin : g_dest
      always_ff @(posedge mclk) begin
        if (done && res_we) begin
          nib_r[i] <= res16[(i-2)*4 +: 4];
        end else if (hit) begin
          nib_r[i] <= io_req.wdata;
        end
      end
    end else begin : g_src
      always_ff @(posedge mclk) begin
        if (hit) begin
          nib_r[i] <= io_req.wdata;
        end
      end
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = 4'h0;
    if (io_req.addr == `MDU_ADDR_CTRL) begin
      rd_mux[`MDU_BIT_NEG] = flg_r.neg;
      rd_mux[`MDU_BIT_OVF] = flg_r.ovf;
      rd_mux[`MDU_BIT_ZERO] = flg_r.zero;
      rd_mux[`MDU_BIT_MODE] = busy;
    end else if (io_req.addr >= `MDU_ADDR_SRC_LO &&
                 io_req.addr <= `MDU_ADDR_DHI_HI) begin
      rd_mux = nib_r[3'(io_req.addr - `MDU_ADDR_SRC_LO)];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      io_rdata_r <= `MDU_RDATA_RESET;
    end else if (io_req.rd) begin
      io_rdata_r <= rd_mux;
    end
  end

  // Checks
  logic src_wr;
  logic [1:0] src_seen_r;
  assign src_wr = io_req.wr && (io_req.addr == `MDU_ADDR_SRC_LO ||
                                io_req.addr == `MDU_ADDR_SRC_HI);

  // Source byte known once both nibbles were written
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      src_seen_r <= 2'b00;
    end else if (io_req.wr && io_req.addr == `MDU_ADDR_SRC_LO) begin
      src_seen_r[0] <= 1'b1;
    end else if (io_req.wr && io_req.addr == `MDU_ADDR_SRC_HI) begin
      src_seen_r[1] <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_run;
    start ##1 (!start)[*8] ##1 !start ##1 !start;
  endsequence

  sequence s_mul;
    start && (io_req.wdata[`MDU_BIT_MODE] == `MDU_MODE_MUL)
      ##1 (!start)[*8] ##1 !start ##1 !start;
  endsequence

  sequence s_div_ok;
    start && (io_req.wdata[`MDU_BIT_MODE] == `MDU_MODE_DIV) && (dhi < src)
      ##1 (!start)[*8] ##1 !start ##1 !start;
  endsequence

  property p_busy_hold;
    s_run |-> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped before the tenth clock");

  property p_busy_end;
    s_run |=> !busy;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy still set after the tenth clock");

  property p_mul_prod;
    s_mul |=> dest16 == ({8'h00, $past(dlo, 11)} * {8'h00, $past(src, 11)});
  endproperty
  a_mul_prod: assert property (p_mul_prod)
    else $error("product wrong or late");

  property p_mul_flags;
    done && (mode_r == `MDU_MODE_MUL) |=>
      flg_r.neg == dhi[7] && !flg_r.ovf && flg_r.zero == (dest16 == 16'h0000);
  endproperty
  a_mul_flags: assert property (p_mul_flags)
    else $error("multiply flags wrong");

  property p_div_ok;
    s_div_ok |=> dlo == 8'({$past(dhi, 11), $past(dlo, 11)} /
                           {8'h00, $past(src, 11)}) && !flg_r.ovf;
  endproperty
  a_div_ok: assert property (p_div_ok)
    else $error("quotient wrong or late");

  property p_div_rem;
    s_div_ok |=> dhi == 8'({$past(dhi, 11), $past(dlo, 11)} %
                           {8'h00, $past(src, 11)});
  endproperty
  a_div_rem: assert property (p_div_rem)
    else $error("remainder wrong or late");

  property p_div_ovf;
    done && (mode_r == `MDU_MODE_DIV) && (cap_hi_r >= cap_src_r) && !io_req.wr
      |=> flg_r.ovf && $stable(dest16);
  endproperty
  a_div_ovf: assert property (p_div_ovf)
    else $error("overflow divide changed dest or missed flag");

  property p_div_nz;
    done && (mode_r == `MDU_MODE_DIV) |=>
      flg_r.neg == dlo[7] && flg_r.zero == (dlo == 8'h00);
  endproperty
  a_div_nz: assert property (p_div_nz)
    else $error("divide flags wrong");

  property p_src_keep;
    !src_wr && (src_seen_r == 2'b11) |=> $stable(src);
  endproperty
  a_src_keep: assert property (p_src_keep)
    else $error("source changed without a write");

  property p_flag_ro;
    !done |=> $stable(flg_r);
  endproperty
  a_flag_ro: assert property (p_flag_ro)
    else $error("flags changed outside completion");

  property p_mul_hi_ign;
    start && (io_req.wdata[`MDU_BIT_MODE] == `MDU_MODE_MUL) |=>
      cap_hi_r == 8'h00;
  endproperty
  a_mul_hi_ign: assert property (p_mul_hi_ign)
    else $error("multiply used high dest byte");

  property p_busy_rise;
    start |=> busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy not set after start");

  property p_mode_latch;
    start |=> mode_r == $past(io_req.wdata[`MDU_BIT_MODE]);
  endproperty
  a_mode_latch: assert property (p_mode_latch)
    else $error("mode not taken from start write");

  property p_cap_ops;
    start && (src_seen_r == 2'b11) |=>
      cap_src_r == $past(src) && cap_lo_r == $past(dlo);
  endproperty
  a_cap_ops: assert property (p_cap_ops)
    else $error("operands not captured at start");

  property p_cap_hold;
    busy && !start |=> $stable({cap_src_r, cap_lo_r, cap_hi_r});
  endproperty
  a_cap_hold: assert property (p_cap_hold)
    else $error("captured operands changed during operation");

  property p_ctrl_rd;
    io_req.rd && (io_req.addr == `MDU_ADDR_CTRL) |=>
      io_rdata_r == {$past(flg_r), $past(busy)};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control read wrong");

  property p_unmapped_rd;
    io_req.rd && (io_req.addr < `MDU_ADDR_SRC_LO ||
                  io_req.addr > `MDU_ADDR_CTRL) |=> io_rdata_r == 4'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped read not zero");

  c_mul: cover property (s_mul);
  c_busy_rd: cover property (io_req.rd && (io_req.addr == `MDU_ADDR_CTRL) &&
                             busy);
  c_div_ok: cover property (s_div_ok);
  c_div_ovf: cover property (done && mode_r && (cap_hi_r >= cap_src_r));
  c_restart: cover property (busy && start);

endmodule // mul_div_unit

/* File: verification/cpu_bus_model.sv */
// Purpose: CPU core side of the I/O bus of the multiply/divide unit.
// Assumes: Strobes one cycle wide, one access per wr or rd call, two per wr_byte or rd_byte call.
// Notes: Released write data is inverted so stale data never passes.
`timescale 1ns/1ps

module cpu_bus_model (
  input wire logic mclk,
  output mul_div_pkg::io_req_s io_req,
  input wire logic [3:0] io_rdata_r
);
  import mul_div_pkg::*;

  initial begin
    io_req = '0;
  end

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge mclk);
    io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk);
    io_req.wr <= 1'b0;
    io_req.wdata <= ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [3:0] d);
    @(posedge mclk);
    io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~io_req.wdata};
    @(posedge mclk);
    io_req.rd <= 1'b0;
    #1 d = io_rdata_r;
  endtask

  // Low nibble at the lower address
  task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
    wr(a, d[3:0]);
    wr(a + 16'h0001, d[7:4]);
  endtask

  task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
    logic [3:0] lo;
    logic [3:0] hi;
    rd(a, lo);
    rd(a + 16'h0001, hi);
    d = {hi, lo};
  endtask
endmodule // cpu_bus_model

/* File: verification/mul_div_unit_8bit_bench.sv */
// Purpose: Self-checking bench of the multiply/divide unit.
// Assumes: Bus accesses made by the CPU model.
// Notes: Results read only after the full operation time.
`timescale 1ns/1ps
`include "mul_div_params.svh"

module mul_div_unit_8bit_bench;
  import mul_div_pkg::*;
  logic mclk;
  logic resetn;
  io_req_s io_req;
  logic [3:0] io_rdata_r;
  int errors;
  int checks_done;
  logic [3:0] last_flg;
  logic [3:0] n;
  logic [7:0] b;

  mul_div_unit #(.OP_CYCLES(10)) mul_div_unit_i (
    .mclk(mclk),
    .resetn(resetn),
    .io_req(io_req),
    .io_rdata_r(io_rdata_r)
  );

  cpu_bus_model cpu_bus_model_i (
    .mclk(mclk),
    .io_req(io_req),
    .io_rdata_r(io_rdata_r)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Load dest, start with read-only bits set, poke dest high mid-op
  task automatic run_op(input logic md, input logic [7:0] dlo, dhi,
                        input bit poke, input logic [7:0] elo, ehi,
                        input logic [3:0] ef);
    logic [3:0] f;
    logic [7:0] r;
    cpu_bus_model_i.wr_byte(`MDU_ADDR_DLO_LO, dlo);
    cpu_bus_model_i.wr_byte(`MDU_ADDR_DHI_LO, dhi);
    cpu_bus_model_i.wr(`MDU_ADDR_CTRL, {3'b111, md});
    if (poke) begin
      cpu_bus_model_i.wr_byte(`MDU_ADDR_DHI_LO, ~dhi);
    end else begin
      repeat (4) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
    cpu_bus_model_i.rd(`MDU_ADDR_CTRL, f);
    chk("ctrl busy", {4'h0, last_flg[3:1], 1'b1}, {4'h0, f});
    cpu_bus_model_i.rd(`MDU_ADDR_CTRL, f);
    chk("ctrl done", {4'h0, ef}, {4'h0, f});
    cpu_bus_model_i.rd_byte(`MDU_ADDR_DLO_LO, r);
    chk("dest low", elo, r);
    cpu_bus_model_i.rd_byte(`MDU_ADDR_DHI_LO, r);
    chk("dest high", ehi, r);
    last_flg = ef;
  endtask

  initial begin
    #400000;
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    last_flg = 4'h0;
    resetn = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    cpu_bus_model_i.rd(`MDU_ADDR_CTRL, n);
    chk("ctrl reset", 8'h00, {4'h0, n});
    cpu_bus_model_i.rd(16'hff87, n);
    chk("unmapped", 8'h00, {4'h0, n});
    cpu_bus_model_i.wr_byte(`MDU_ADDR_SRC_LO, 8'ha5);
    run_op(1'b0, 8'hc8, 8'h5a, 1'b1, 8'he8, 8'h80, 4'h8);
    cpu_bus_model_i.wr_byte(`MDU_ADDR_SRC_LO, 8'h64);
    run_op(1'b0, 8'h00, 8'hff, 1'b0, 8'h00, 8'h00, 4'h2);
    run_op(1'b1, 8'h16, 8'h1a, 1'b1, 8'h42, 8'h4e, 4'h0);
    run_op(1'b1, 8'h2c, 8'h33, 1'b0, 8'h83, 8'h00, 4'h8);
    run_op(1'b1, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 4'h2);
    cpu_bus_model_i.wr_byte(`MDU_ADDR_SRC_LO, 8'h13);
    run_op(1'b1, 8'h68, 8'h24, 1'b0, 8'h68, 8'h24, 4'h4);
    run_op(1'b1, 8'h24, 8'h00, 1'b0, 8'h01, 8'h11, 4'h0);
    run_op(1'b1, 8'h68, 8'h11, 1'b0, 8'hea, 8'h0a, 4'h8);
    cpu_bus_model_i.rd_byte(`MDU_ADDR_SRC_LO, b);
    chk("source kept", 8'h13, b);
    cpu_bus_model_i.wr_byte(`MDU_ADDR_SRC_LO, 8'h58);
    run_op(1'b0, 8'hc8, 8'h77, 1'b0, 8'hc0, 8'h44, 4'h0);
    run_op(1'b0, 8'h64, 8'h00, 1'b1, 8'h60, 8'h22, 4'h0);
    give_verdict();
  end
endmodule // mul_div_unit_8bit_bench
